// file: pwi_port_wake_irq.sv
// per-port wake event flags, wake enables and interrupt status with an avalon slave
//
// Overview of operation
// - wake frame detection sets wake flag bit 2; software clears it by writing one.
// - a wake frame counts only if its destination equals the switch address.
// - link-up sets wake flag bit 1, held until software clears it.
// - cable energy sets wake flag bit 0, held until software clears it.
// - link-up and energy flags exist only on ports with an integrated phy.
// - enable bit 2 lets a wake frame drive the wake output pin.
// - enable bit 1 lets link-up drive the wake output pin.
// - enable bit 0 lets cable energy drive the wake output pin.
// - a status bit interrupts only when its mask bit allows it.
// - status bit 3 shows serdes auto-negotiation done, on port 7 only.
// - status bit 2 shows any pending timing interrupt, phy ports only.
// - status bit 0 shows an access-list counter interrupt, on every port.
// - toggling mask bit 0 clears the access-list status bit.
// - mask bit zero enables, one disables; all mask bits reset to zero.
`timescale 1ns/100ps
`include "pwi_defines.svh"
module pwi_port_wake_irq #(
  parameter int PORT_NUM = 1
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [10:0] avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  // wake sources
  input  wire logic        wakeFrameSeen,
  input  wire logic [47:0] wakeFrameDest,
  input  wire logic        linkUpEvent,
  input  wire logic        energyEvent,
  // interrupt sources
  input  wire logic        sgmiiAnDone,
  input  wire logic        ptpIrqPending,
  input  wire logic        phyIrqPending,
  input  wire logic        aclCountIrq,
  // outputs to the system
  output logic             powerWakeOut,
  output logic             portIrqOut
);

  // ---------------------------------------------------------------
  // elaboration checks and port class
  // ---------------------------------------------------------------
  if (PORT_NUM < `PWI_FIRST_PORT || PORT_NUM > `PWI_LAST_PORT) begin : gPortCheck
    $error("pwi_port_wake_irq: PORT_NUM out of range");
  end

  localparam bit HAS_PHY  = (PORT_NUM <= `PWI_LAST_PHY_PORT);
  localparam bit IS_SGMII = (PORT_NUM == `PWI_SGMII_PORT);

  // merges written byte lanes over the old word
  function automatic logic [31:0] laneMerge(input logic [31:0] oldWord,
                                            input logic [31:0] newWord,
                                            input logic [3:0]  lanes);
    logic [31:0] merged;
    merged = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        merged[8*i +: 8] = newWord[8*i +: 8];
      end
    end
    return merged;
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  pwi_pkg::pwi_avl_req_t req;
  logic                  reqValid;
  logic                  ack_reg;
  logic                  accept;
  logic                  wrAccept;
  logic [8:0]            regIdx;
  logic                  hitWakeFlags;
  logic                  hitWakeEn;
  logic                  hitIrqFlags;
  logic                  hitIrqMask;
  logic                  hitMacLo;
  logic                  hitMacHi;
  logic                  lane0;

  assign req          = '{read: avsRead, write: avsWrite, address: avsAddress,
                          writeData: avsWriteData, byteEnable: avsByteEnable};
  assign reqValid     = req.read | req.write;
  // one wait cycle: the answer is ready on the cycle after the request appears;
  // a low enable keeps waitrequest up so the master never leaves an unserved access
  assign avsWaitRequest = reqValid & ~(ack_reg & ce);
  assign accept       = ce & ack_reg & reqValid;
  assign wrAccept     = accept & req.write;
  assign regIdx       = req.address[10:2];
  assign hitWakeFlags = (regIdx == `PWI_IDX_WAKE_FLAGS);
  assign hitWakeEn    = (regIdx == `PWI_IDX_WAKE_ENABLES);
  assign hitIrqFlags  = (regIdx == `PWI_IDX_IRQ_FLAGS);
  assign hitIrqMask   = (regIdx == `PWI_IDX_IRQ_MASK);
  assign hitMacLo     = (regIdx == `PWI_IDX_MAC_LO);
  assign hitMacHi     = (regIdx == `PWI_IDX_MAC_HI);
  assign lane0        = req.byteEnable[0];

  // handshake phase: high only for the single answering cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= reqValid & ~ack_reg;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [2:0]  wakeEnable_reg;
  logic [3:0]  irqMask_reg;
  logic [47:0] switchMac_reg;
  logic [31:0] macLo_next;
  logic [31:0] macHi_next;
  logic        aclToggle;

  assign macLo_next = laneMerge(switchMac_reg[31:0], req.writeData, req.byteEnable);
  assign macHi_next = laneMerge({16'h0, switchMac_reg[47:32]}, req.writeData,
                                req.byteEnable);
  assign aclToggle  = wrAccept & hitIrqMask & lane0
                      & (req.writeData[`PWI_BIT_ACL] != irqMask_reg[`PWI_BIT_ACL]);

  // enables, mask and switch address; reserved bits are not stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wakeEnable_reg <= `PWI_RST_WAKE;
      irqMask_reg    <= `PWI_RST_MASK;
      switchMac_reg  <= `PWI_RST_MAC;
    end else if (ce) begin
      if (wrAccept && hitWakeEn && lane0) begin
        wakeEnable_reg <= req.writeData[`PWI_WAKE_W-1:0];
      end
      if (wrAccept && hitIrqMask && lane0) begin
        irqMask_reg <= req.writeData[`PWI_IRQ_W-1:0];
      end
      if (wrAccept && hitMacLo) begin
        switchMac_reg[31:0] <= macLo_next;
      end
      if (wrAccept && hitMacHi) begin
        switchMac_reg[47:32] <= macHi_next[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // wake event flags
  // ---------------------------------------------------------------
  logic       wakeMatch;
  logic [2:0] wakeSet;
  logic [2:0] wakeClr;
  logic [2:0] wakeFlags_reg;

  pwi_mac_match uMacMatch (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .frameSeen (wakeFrameSeen),
    .frameDest (wakeFrameDest),
    .switchMac (switchMac_reg),
    .match_reg (wakeMatch)
  );

  // event sources; phy-less ports never set link or energy
  assign wakeSet = {wakeMatch, linkUpEvent & HAS_PHY, energyEvent & HAS_PHY};
  assign wakeClr = (wrAccept && hitWakeFlags && lane0) ?
                   req.writeData[`PWI_WAKE_W-1:0] : `PWI_RST_WAKE;

  pwi_sticky_bits #(.WIDTH(`PWI_WAKE_W)) uWakeFlags (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .setBits   (wakeSet),
    .clrBits   (wakeClr),
    .flags_reg (wakeFlags_reg)
  );

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  logic                    aclFlag_reg;
  pwi_pkg::pwi_irq_stat_t  irqStat;

  // counter interrupt held until the mask bit is toggled
  pwi_sticky_bits #(.WIDTH(1)) uAclFlag (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .setBits   (aclCountIrq),
    .clrBits   (aclToggle),
    .flags_reg (aclFlag_reg)
  );

  // live summary bits except acl, which is held here; the other sources keep their own pending state
  assign irqStat = '{sgmiiDone: sgmiiAnDone & IS_SGMII,
                     ptp:       ptpIrqPending & HAS_PHY,
                     phy:       phyIrqPending & HAS_PHY,
                     acl:       aclFlag_reg};

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic wakeAny;
  logic irqAny;

  // enabled flags drive the wake pin
  assign wakeAny = |(wakeFlags_reg & wakeEnable_reg);
  // mask zero lets the bit through
  assign irqAny  = |(irqStat & ~irqMask_reg);

  // registered pins, one cycle behind the flags, to keep them glitch free
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      powerWakeOut <= 1'b0;
      portIrqOut   <= 1'b0;
    end else if (ce) begin
      powerWakeOut <= wakeAny;
      portIrqOut   <= irqAny;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] readMux;

  // unmapped addresses and reserved bits read zero
  assign readMux = hitWakeFlags ? {29'h0, wakeFlags_reg}  :
                   hitWakeEn    ? {29'h0, wakeEnable_reg} :
                   hitIrqFlags  ? {28'h0, irqStat}        :
                   hitIrqMask   ? {28'h0, irqMask_reg}    :
                   hitMacLo     ? switchMac_reg[31:0]     :
                   hitMacHi     ? {16'h0, switchMac_reg[47:32]} : `PWI_RST_WORD;

  // captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avsReadData <= `PWI_RST_WORD;
    end else if (ce && req.read && !ack_reg) begin
      avsReadData <= readMux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  linkFlagSet_a: assert property (
    (ce && linkUpEvent && HAS_PHY) |=> wakeFlags_reg[`PWI_BIT_LINK_UP])
    else $error("link-up event not latched");

  energyFlagSet_a: assert property (
    (ce && energyEvent && HAS_PHY) |=> wakeFlags_reg[`PWI_BIT_ENERGY])
    else $error("energy event not latched");

  noPhyFlags_a: assert property (
    !HAS_PHY |-> (wakeFlags_reg[1:0] == 2'h0))
    else $error("phy event flag set on a phy-less port");

  wakeFrameFlag_a: assert property (
    (ce && wakeMatch) |=> wakeFlags_reg[`PWI_BIT_WAKE_FRAME])
    else $error("matched wake frame not latched");

  wakePinFrame_a: assert property (
    (ce && wakeFlags_reg[2] && wakeEnable_reg[2]) |=> powerWakeOut)
    else $error("enabled wake frame did not raise wake pin");

  wakePinLink_a: assert property (
    (ce && wakeFlags_reg[1] && wakeEnable_reg[1]) |=> powerWakeOut)
    else $error("enabled link-up did not raise wake pin");

  wakePinEnergy_a: assert property (
    (ce && wakeFlags_reg[0] && wakeEnable_reg[0]) |=> powerWakeOut)
    else $error("enabled energy did not raise wake pin");

  wakePinIdle_a: assert property (
    (ce && ((wakeFlags_reg & wakeEnable_reg) == 3'h0)) |=> !powerWakeOut)
    else $error("wake pin high with nothing enabled");

  sgmiiOnly_a: assert property (
    !IS_SGMII |-> !irqStat.sgmiiDone)
    else $error("serdes done bit on a non-serdes port");

  phyOnly_a: assert property (
    !HAS_PHY |-> (!irqStat.ptp && !irqStat.phy))
    else $error("phy status bit on a phy-less port");

  aclSet_a: assert property (
    (ce && aclCountIrq) |=> (aclFlag_reg ##0 irqStat.acl))
    else $error("acl counter interrupt not latched");

  aclToggleClr_a: assert property (
    (aclToggle && !aclCountIrq) |=> !aclFlag_reg)
    else $error("mask toggle did not clear acl status");

  irqFollows_a: assert property (
    ce |=> (portIrqOut == $past(irqAny)))
    else $error("interrupt request does not follow enabled status");

  maskBlocks_a: assert property (
    (ce && (irqMask_reg == 4'hf)) |=> !portIrqOut)
    else $error("fully masked status raised an interrupt");

  waitOne_a: assert property (
    (ce && reqValid && !ack_reg) ##1 ce |-> (ack_reg && !avsWaitRequest))
    else $error("bus answer not given after one wait cycle");

  wakePinCov_c: cover property (!powerWakeOut ##1 powerWakeOut);
  aclClearCov_c: cover property (aclFlag_reg && aclToggle ##1 !aclFlag_reg);
  irqRiseCov_c: cover property (!portIrqOut ##1 portIrqOut);
  busReadCov_c: cover property (accept && req.read && hitIrqFlags);

endmodule // pwi_port_wake_irq

// file: pwi_defines.svh
// register offsets, field positions, reset values and sizes for the port wake block
`ifndef PWI_DEFINES_SVH
`define PWI_DEFINES_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define PWI_IDX_W            9
`define PWI_ADDR_W           11
`define PWI_IDX_WAKE_FLAGS   9'h013
`define PWI_IDX_WAKE_ENABLES 9'h017
`define PWI_IDX_IRQ_FLAGS    9'h01b
`define PWI_IDX_IRQ_MASK     9'h01f
`define PWI_IDX_MAC_LO       9'h100
`define PWI_IDX_MAC_HI       9'h101

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PWI_BIT_WAKE_FRAME   2
`define PWI_BIT_LINK_UP      1
`define PWI_BIT_ENERGY       0
`define PWI_BIT_SGMII_DONE   3
`define PWI_BIT_PTP          2
`define PWI_BIT_PHY          1
`define PWI_BIT_ACL          0
`define PWI_WAKE_W           3
`define PWI_IRQ_W            4

// ---------------------------------------------------------------
// reset values and port numbering
// ---------------------------------------------------------------
`define PWI_RST_WAKE         3'h0
`define PWI_RST_MASK         4'h0
`define PWI_RST_MAC          48'h0
`define PWI_RST_WORD         32'h0
`define PWI_SGMII_PORT       7
`define PWI_LAST_PHY_PORT    5
`define PWI_FIRST_PORT       1
`define PWI_LAST_PORT        7

`endif

// file: pwi_pkg.sv
// shared types of the port wake and interrupt status block
package pwi_pkg;

  // bus request as seen by the register file
  typedef struct packed {
    logic        read;
    logic        write;
    logic [10:0] address;
    logic [31:0] writeData;
    logic [3:0]  byteEnable;
  } pwi_avl_req_t;

  // summary of port interrupt sources, msb first
  typedef struct packed {
    logic sgmiiDone;
    logic ptp;
    logic phy;
    logic acl;
  } pwi_irq_stat_t;

endpackage

// file: pwi_sticky_bits.sv
// sticky event flags: hardware sets, a clear vector drops them, set wins
`timescale 1ns/100ps
module pwi_sticky_bits #(
  parameter int WIDTH = 3
) (
  // clock, reset, enable
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // set and clear requests
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic [WIDTH-1:0] clrBits,
  // held flags
  output logic      [WIDTH-1:0] flags_reg
);

  if (WIDTH < 1) begin : gWidthCheck
    $error("pwi_sticky_bits: WIDTH must be at least one");
  end

  logic [WIDTH-1:0] flags_next;

  // an event in the clear cycle survives the clear
  assign flags_next = (flags_reg & ~clrBits) | setBits;

  // ---------------------------------------------------------------
  // flag storage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_reg <= '0;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  setWins_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> ((flags_reg & $past(setBits)) == $past(setBits)))
    else $error("a set request was lost");

  clearHolds_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && (setBits == '0)) |=> ((flags_reg & $past(clrBits)) == '0))
    else $error("a cleared flag stayed set");

endmodule // pwi_sticky_bits

// file: pwi_mac_match.sv
// compares a wake frame destination with the switch address, one-cycle pulse out
`timescale 1ns/100ps
module pwi_mac_match (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // candidate wake frame
  input  wire logic        frameSeen,
  input  wire logic [47:0] frameDest,
  // switch address
  input  wire logic [47:0] switchMac,
  // qualified detection
  output logic             match_reg
);

  logic addrEqual;

  // all six bytes must agree
  assign addrEqual = (frameDest == switchMac);

  // ---------------------------------------------------------------
  // registered match pulse
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_reg <= 1'b0;
    end else if (ce) begin
      match_reg <= frameSeen & addrEqual;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  matchCause_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(ce) && match_reg) |-> ($past(frameSeen) && ($past(frameDest) == $past(switchMac))))
    else $error("wake match without an equal destination");

  mismatchQuiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && frameSeen && !addrEqual) |=> !match_reg)
    else $error("wake match on a foreign destination");

endmodule // pwi_mac_match

// file: pwi_port_wake_irq_tb.sv
// self-checking bench for the port wake and interrupt status block, ports 1 and 7
`timescale 1ns/100ps
module pwi_port_wake_irq_tb;
  // ---------------------------------------------------------------
  // stimulus, observed outputs and reference model state
  // ---------------------------------------------------------------
  logic        ref_clk       = 1'b0;
  logic        rst           = 1'b1;
  logic        ce            = 1'b1;
  logic [10:0] avsAddress    = 11'h000;
  logic        avsRead       = 1'b0;
  logic        avsWrite      = 1'b0;
  logic [31:0] avsWriteData  = 32'h0;
  logic [3:0]  avsByteEnable = 4'hf;
  logic        wakeFrameSeen = 1'b0;
  logic [47:0] wakeFrameDest = 48'h0;
  logic        linkUpEvent   = 1'b0;
  logic        energyEvent   = 1'b0;
  logic        sgmiiAnDone   = 1'b0;
  logic        ptpIrqPending = 1'b0;
  logic        phyIrqPending = 1'b0;
  logic        aclCountIrq   = 1'b0;
  logic [31:0] rdData1, rdData7, q1, q7, rnd;
  logic        waitReq1, waitReq7, wake1Out, wake7Out, irq1Out, irq7Out;
  logic [2:0]  mWake1 = 3'h0;
  logic [2:0]  mWake7 = 3'h0;
  logic [2:0]  mEn    = 3'h0;
  logic [3:0]  mMask  = 4'h0;
  logic        mAcl   = 1'b0;
  logic [47:0] mMac   = 48'h0;
  int          nErrors  = 0;
  int          cmpCount = 0;
  int          seed     = 32'h1c9c7324;

  // 250 MHz core clock
  always #2 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // a phy port and the serdes port share every input
  // ---------------------------------------------------------------
  pwi_port_wake_irq #(.PORT_NUM(1)) i_pwi_port_wake_irq (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(rdData1), .avsWaitRequest(waitReq1), .wakeFrameSeen(wakeFrameSeen),
    .wakeFrameDest(wakeFrameDest), .linkUpEvent(linkUpEvent), .energyEvent(energyEvent),
    .sgmiiAnDone(sgmiiAnDone), .ptpIrqPending(ptpIrqPending), .phyIrqPending(phyIrqPending),
    .aclCountIrq(aclCountIrq), .powerWakeOut(wake1Out), .portIrqOut(irq1Out));

  pwi_port_wake_irq #(.PORT_NUM(7)) i_pwi_port_wake_irq_p7 (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(rdData7), .avsWaitRequest(waitReq7), .wakeFrameSeen(wakeFrameSeen),
    .wakeFrameDest(wakeFrameDest), .linkUpEvent(linkUpEvent), .energyEvent(energyEvent),
    .sgmiiAnDone(sgmiiAnDone), .ptpIrqPending(ptpIrqPending), .phyIrqPending(phyIrqPending),
    .aclCountIrq(aclCountIrq), .powerWakeOut(wake7Out), .portIrqOut(irq7Out));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic finishTest();
    $display("errors %0d compares %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic checkVal(input logic [31:0] seen, input logic [31:0] expVal);
    cmpCount++;
    if (seen !== expVal) begin
      nErrors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expVal);
    end
  endtask

  // ---------------------------------------------------------------
  // avalon master: hold the request until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic busXfer(input logic wr, input logic [10:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    n = 0;
    // both ports see the same request, so port 1 paces the transfer
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitReq1 !== 1'b0 && n < 20);
    if (n >= 20) begin
      nErrors++;
      finishTest();
    end
    q1 = rdData1;
    q7 = rdData7;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  // model update then bus write; clears and toggles follow the register map
  task automatic regWr(input logic [10:0] a, input logic [31:0] d);
    case (a)
      11'h04c: begin
        mWake1 &= ~d[2:0];
        mWake7 &= ~d[2:0];
      end
      11'h05c: mEn = d[2:0];
      11'h07c: begin
        if (d[0] != mMask[0]) mAcl = 1'b0;
        mMask = d[3:0];
      end
      11'h400: mMac[31:0] = d;
      11'h404: mMac[47:32] = d[15:0];
      default: ;
    endcase
    busXfer(1'b1, a, d);
  endtask

  // ---------------------------------------------------------------
  // event pulses: 0 energy, 1 link, 2 matching frame, 3 foreign frame, 4 acl
  // ---------------------------------------------------------------
  task automatic pulseEvt(input int kind);
    logic [31:0] r;
    r = $random(seed);
    @(posedge ref_clk);
    case (kind)
      0: begin
        energyEvent <= 1'b1;
        mWake1[0] = 1'b1;
      end
      1: begin
        linkUpEvent <= 1'b1;
        mWake1[1] = 1'b1;
      end
      2: begin
        wakeFrameSeen <= 1'b1;
        wakeFrameDest <= mMac;
        mWake1[2] = 1'b1;
        mWake7[2] = 1'b1;
      end
      3: begin
        wakeFrameSeen <= 1'b1;
        wakeFrameDest <= mMac ^ (48'h1 << (r % 48));
      end
      default: begin
        aclCountIrq <= 1'b1;
        mAcl = 1'b1;
      end
    endcase
    @(posedge ref_clk);
    energyEvent   <= 1'b0;
    linkUpEvent   <= 1'b0;
    wakeFrameSeen <= 1'b0;
    aclCountIrq   <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // level sources {sgmii, ptp, phy}
  task automatic setLevels(input logic [2:0] v);
    @(posedge ref_clk);
    {sgmiiAnDone, ptpIrqPending, phyIrqPending} <= v;
  endtask

  // compares pins, wake flags and status of both ports, port 1 enables and port 7 mask with the model
  task automatic checkAll();
    logic [3:0] st1, st7;
    // registered outputs lag their cause by up to three edges
    repeat (3) @(posedge ref_clk);
    st1 = {1'b0, ptpIrqPending, phyIrqPending, mAcl};
    st7 = {sgmiiAnDone, 2'b00, mAcl};
    checkVal({31'h0, wake1Out}, {31'h0, |(mWake1 & mEn)});
    checkVal({31'h0, wake7Out}, {31'h0, |(mWake7 & mEn)});
    checkVal({31'h0, irq1Out}, {31'h0, |(st1 & ~mMask)});
    checkVal({31'h0, irq7Out}, {31'h0, |(st7 & ~mMask)});
    busXfer(1'b0, 11'h04c, 32'h0);
    checkVal(q1, {29'h0, mWake1});
    checkVal(q7, {29'h0, mWake7});
    busXfer(1'b0, 11'h05c, 32'h0);
    checkVal(q1, {29'h0, mEn});
    busXfer(1'b0, 11'h06c, 32'h0);
    checkVal(q1, {28'h0, st1});
    checkVal(q7, {28'h0, st7});
    busXfer(1'b0, 11'h07c, 32'h0);
    checkVal(q7, {28'h0, mMask});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, then an unmapped place that must ignore writes
    checkAll();
    regWr(11'h300, 32'hffffffff);
    busXfer(1'b0, 11'h300, 32'h0);
    checkVal(q1, 32'h0);
    rnd = $random(seed);
    regWr(11'h400, rnd);
    rnd = $random(seed);
    regWr(11'h404, rnd);
    // foreign frame first, then a matching one, enable afterwards, clear
    pulseEvt(3);
    checkAll();
    pulseEvt(2);
    checkAll();
    regWr(11'h05c, 32'h4);
    checkAll();
    regWr(11'h04c, 32'h4);
    checkAll();
    // energy and link, once enabled and once with only the others enabled
    for (int b = 0; b < 2; b++) begin
      regWr(11'h05c, 32'h1 << b);
      pulseEvt(b);
      checkAll();
      regWr(11'h04c, 32'h7);
      regWr(11'h05c, ~(32'h1 << b) & 32'h7);
      pulseEvt(b);
      checkAll();
      regWr(11'h04c, 32'h7);
    end
    // level sources, unmasked then masked
    for (int b = 1; b < 4; b++) begin
      setLevels(3'h1 << (b - 1));
      checkAll();
      regWr(11'h07c, 32'h1 << b);
      checkAll();
      regWr(11'h07c, 32'h0);
      setLevels(3'h0);
    end
    // acl: status write has no effect, same-value mask write neither, a toggle clears
    pulseEvt(4);
    regWr(11'h06c, 32'hf);
    checkAll();
    regWr(11'h07c, 32'h0);
    checkAll();
    regWr(11'h07c, 32'h1);
    checkAll();
    pulseEvt(4);
    checkAll();
    regWr(11'h07c, 32'h0);
    checkAll();
    // clock enable low: a link event in the frozen time is not latched
    regWr(11'h04c, 32'h7);
    ce <= 1'b0;
    pulseEvt(1);
    mWake1 = 3'h0;
    ce <= 1'b1;
    checkAll();
    // a write without lane 0 leaves the enables alone
    avsByteEnable <= 4'he;
    busXfer(1'b1, 11'h05c, ~{29'h0, mEn});
    avsByteEnable <= 4'hf;
    checkAll();
    // random mix of enables, masks, levels and events
    repeat (16) begin
      rnd = $random(seed);
      regWr(11'h05c, rnd);
      rnd = $random(seed);
      regWr(11'h07c, rnd);
      rnd = $random(seed);
      setLevels(rnd[2:0]);
      rnd = $random(seed);
      pulseEvt(rnd % 5);
      checkAll();
      rnd = $random(seed);
      regWr(11'h04c, rnd);
      checkAll();
    end
    finishTest();
  end
endmodule // pwi_port_wake_irq_tb
